/* hdl/reset_cause.sv */
// Reset source collector with cause flag register on Avalon-MM
// -------------------------------------------------------------------
// Summary of operation
// - Low reset pin resets the system
// - Reset pin pulses shorter than minimum ignored
// - Software reset lasts one cycle, clock kept
// - Watchdog time-out resets asynchronously, clock kept
// - Watchdog time-out in sleep/idle wakes only
// - Hard trap conflict at levels 13-15 resets
// - Pin-select registers compared against shadow copy
// - Upper byte 3Fh opcode resets device
// - Uninitialized working register pointer use resets
// - Flow change into protected segment resets
// - Trap conflict sets bit 15
// - Illegal conditions set bit 14
// - Configuration mismatch sets bit 9
// - Pin reset sets bit 7, power-on clears
// - Software reset sets bit 6
// - Watchdog sets bit 4, power-save/clear clears
// - Sleep sets bit 3, idle sets bit 2
// - Software writes any flag either way
// - Brown-out/power-on set bit 1, power-on bit 0
// - Software flag writes never cause reset
// - Only cold resets reselect the clock source
// -------------------------------------------------------------------
`timescale 1ns/1ns
module reset_cause
    import reset_cause_pkg::*;
#(
    parameter int FILTER_CYC = PIN_FILTER_CYC,
    parameter int NREG = NUM_WREGS
) (
    input wire logic mclk, // 20 MHz instruction clock
    input wire logic resetn, // Power-on reset, active low
    input wire logic brownOut, // Brown-out event, one cycle
    input wire logic masterClearPin_n, // External reset pin, low asserts
    input wire logic softResetInstr, // Reset instruction executed
    input wire logic watchdogTimeout, // Watchdog time-out level
    input wire logic sleepInstr, // Power-save instruction, sleep form
    input wire logic idleInstr, // Power-save instruction, idle form
    input wire logic watchdogClearInstr, // Watchdog clear instruction
    input wire logic cpuAsleep, // Core in sleep or idle
    input wire logic trapActive, // A trap is being serviced
    input wire logic [3:0] trapActiveLevel, // Level of serviced trap
    input wire logic trapNew, // New trap raised
    input wire logic [3:0] trapNewLevel, // Level of new trap
    input wire logic [PPS_WIDTH-1:0] ppsControl, // Pin-select control
    input wire logic [23:0] fetchWord, // Instruction word to execute
    input wire logic fetchValid, // Instruction word is executed
    input wire logic regWrite, // Working register written
    input wire logic [3:0] regWriteIdx, // Index of written register
    input wire logic ptrUse, // Working register used as pointer
    input wire logic [3:0] ptrIdx, // Index of pointer register
    input wire logic flowChange, // Program or vector flow change
    input wire logic flowRestricted, // Target in protected segment
    input wire logic [3:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait request
    output logic systemReset_n, // Merged system reset, low active
    output logic warmReset, // Reset keeps clock source
    output logic coldReset, // Reset reselects clock from config
    output logic wakeRequest // Wake core from sleep or idle
);
    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] shadow;
        logic [NREG-1:0] regValid;
        logic mismatchEn;
        logic [31:0] rdata;
        logic ack;
        logic rstOut_n;
        logic warm;
        logic cold;
        logic wake;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic pinLow;
    logic wdogReset;
    logic trapConflict;
    logic mismatch;
    logic illegalOp;
    logic uninitPtr;
    logic securityHit;
    logic anyWarm;
    logic [15:0] wmask;

    // -----------------------------------------------------------------
    // Pin filter
    // -----------------------------------------------------------------
    pin_glitch_filter #(
        .FILTER_CYC(FILTER_CYC)
    ) u_filter (
        .mclk(mclk),
        .resetn(resetn),
        .pinIn_n(masterClearPin_n),
        .pinLow(pinLow)
    );

    // -----------------------------------------------------------------
    // Reset source detection
    // -----------------------------------------------------------------
    // Watchdog resets only while awake, otherwise it wakes the core
    assign wdogReset = watchdogTimeout && !cpuAsleep;
    assign trapConflict = trapActive && trapNew
        && trapNewLevel >= HARD_TRAP_LOW && trapNewLevel <= HARD_TRAP_HIGH
        && trapNewLevel < trapActiveLevel;
    assign mismatch = state_reg.mismatchEn
        && (ppsControl != state_reg.shadow);
    assign illegalOp = fetchValid
        && (fetchWord[23:16] == ILLEGAL_OPCODE);
    assign uninitPtr = ptrUse && !state_reg.regValid[ptrIdx];
    assign securityHit = flowChange && flowRestricted;
    // Merged warm sources; software register writes are not among them
    assign anyWarm = pinLow || softResetInstr || wdogReset || trapConflict
        || mismatch || illegalOp || uninitPtr || securityHit;

    // Byte enables widened to the 16-bit flag field
    assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.wake = watchdogTimeout && cpuAsleep;
        // Bus access: software writes come first, hardware sets win
        if ((read || write) && !state_reg.ack) begin
            state_next.ack = 1'b1;
            state_next.rdata = 32'h0000_0000;
            unique case (address)
                ADDR_FLAGS: begin
                    if (write) begin
                        state_next.flags = (state_reg.flags & ~wmask)
                            | (writedata[15:0] & wmask & FLAG_MASK);
                    end
                    state_next.rdata = {16'h0000, state_reg.flags};
                end
                ADDR_CONTROL: begin
                    if (write && byteenable[0]) begin
                        state_next.mismatchEn = writedata[0];
                    end
                    state_next.rdata = {31'h0, state_reg.mismatchEn};
                end
                ADDR_STATUS: begin
                    state_next.rdata = {29'h0, state_reg.cold,
                        state_reg.warm, state_reg.rstOut_n};
                end
                ADDR_SHADOW: begin
                    state_next.rdata = {16'h0000, state_reg.shadow};
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Shadow tracks the control copy while checking is off
        if (!state_reg.mismatchEn) begin
            state_next.shadow = ppsControl;
        end
        // Working register validity
        if (regWrite) begin
            state_next.regValid[regWriteIdx] = 1'b1;
        end
        // Hardware clears
        if (brownOut) begin
            state_next.flags = state_reg.flags
                & ~(FLAG_MASK & ~(16'h0001 << BIT_PIN)
                    & ~(16'h0001 << BIT_POWER));
        end
        if (sleepInstr || idleInstr || watchdogClearInstr) begin
            state_next.flags[BIT_WDOG] = 1'b0;
        end
        // Hardware sets, same cycle as the reset
        if (trapConflict) state_next.flags[BIT_TRAP] = 1'b1;
        if (illegalOp || uninitPtr || securityHit) begin
            state_next.flags[BIT_ILLEGAL] = 1'b1;
        end
        if (mismatch) state_next.flags[BIT_MISMATCH] = 1'b1;
        if (pinLow) state_next.flags[BIT_PIN] = 1'b1;
        if (softResetInstr) state_next.flags[BIT_SOFT] = 1'b1;
        if (wdogReset) state_next.flags[BIT_WDOG] = 1'b1;
        if (sleepInstr) state_next.flags[BIT_SLEEP] = 1'b1;
        if (idleInstr) state_next.flags[BIT_IDLE] = 1'b1;
        if (brownOut) state_next.flags[BIT_BROWN] = 1'b1;
        // System reset: warm sources keep clock, brown-out is cold
        state_next.rstOut_n = !(anyWarm || brownOut);
        state_next.warm = anyWarm && !brownOut;
        state_next.cold = brownOut;
        if (anyWarm || brownOut) begin
            // Every reset clears working registers except 15
            state_next.regValid = '0;
            state_next.regValid[NREG-1] = 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    // Power-on state: flags show power-on and brown-out only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
            state_reg.flags <= RESET_FLAGS
                | (16'h0001 << BIT_POWER) | (16'h0001 << BIT_BROWN);
            state_reg.regValid <= {1'b1, {(NREG-1){1'b0}}};
            state_reg.rstOut_n <= 1'b0;
            state_reg.cold <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    // Watchdog asserts reset without waiting for a clock edge
    assign systemReset_n = state_reg.rstOut_n && !wdogReset;
    assign warmReset = state_reg.warm;
    assign coldReset = state_reg.cold;
    assign wakeRequest = state_reg.wake;
    assign readdata = state_reg.rdata;
    assign waitrequest = (read || write) && !state_reg.ack;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    a_soft_one_cycle: assert property (@(posedge mclk)
        disable iff (!resetn) softResetInstr && !brownOut
        |=> !systemReset_n && warmReset) else $error("Soft reset lost");
    a_soft_release: assert property (@(posedge mclk)
        disable iff (!resetn) $past(softResetInstr) && !anyWarm && !brownOut
        |=> state_reg.rstOut_n) else $error("Soft reset not released");
    a_pin_flag: assert property (@(posedge mclk)
        disable iff (!resetn) pinLow && !brownOut
        |=> state_reg.flags[BIT_PIN] && !systemReset_n)
        else $error("Pin reset not seen");
    a_wdog_async: assert property (@(posedge mclk)
        disable iff (!resetn) wdogReset && !brownOut
        |-> !systemReset_n ##1 (state_reg.flags[BIT_WDOG] && warmReset))
        else $error("Watchdog did not reset");
    a_wdog_wake: assert property (@(posedge mclk)
        disable iff (!resetn) watchdogTimeout && cpuAsleep && !anyWarm
        && !brownOut |=> wakeRequest && state_reg.rstOut_n)
        else $error("Sleep time-out misbehaved");
    a_trap_flag: assert property (@(posedge mclk)
        disable iff (!resetn) trapConflict && !brownOut
        |=> state_reg.flags[BIT_TRAP] && warmReset)
        else $error("Trap conflict missed");
    a_illegal_flag: assert property (@(posedge mclk)
        disable iff (!resetn) illegalOp || uninitPtr || securityHit
        |=> state_reg.flags[BIT_ILLEGAL] && !systemReset_n)
        else $error("Illegal condition missed");
    a_mismatch_flag: assert property (@(posedge mclk)
        disable iff (!resetn) mismatch |=> state_reg.flags[BIT_MISMATCH])
        else $error("Mismatch flag not set");
    a_brown_keeps_pin: assert property (@(posedge mclk)
        disable iff (!resetn) brownOut && !(write && address == ADDR_FLAGS)
        |=> state_reg.flags[BIT_PIN] == $past(state_reg.flags[BIT_PIN])
            || $past(pinLow))
        else $error("Brown-out altered pin flag");
    a_write_no_reset: assert property (@(posedge mclk)
        disable iff (!resetn) write && !anyWarm && !brownOut
        |=> state_reg.rstOut_n) else $error("Flag write caused reset");
    a_reg_cleared: assert property (@(posedge mclk)
        disable iff (!resetn) anyWarm
        |=> state_reg.regValid[NREG-2:0] == '0)
        else $error("Registers not marked uninitialized");
endmodule

/* shared/reset_cause_pkg.sv */
// Package for the reset source collector and cause flag register
package reset_cause_pkg;
    // -----------------------------------------------------------------
    // Register map (byte addresses, word aligned)
    // -----------------------------------------------------------------
    localparam logic [3:0] ADDR_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_SHADOW = 4'hc;

    // -----------------------------------------------------------------
    // Cause flag bit positions
    // -----------------------------------------------------------------
    localparam int BIT_TRAP = 15;
    localparam int BIT_ILLEGAL = 14;
    localparam int BIT_MISMATCH = 9;
    localparam int BIT_PIN = 7;
    localparam int BIT_SOFT = 6;
    localparam int BIT_WDOG = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_IDLE = 2;
    localparam int BIT_BROWN = 1;
    localparam int BIT_POWER = 0;
    localparam logic [15:0] FLAG_MASK = 16'hc2df;

    // -----------------------------------------------------------------
    // Encodings and timing
    // -----------------------------------------------------------------
    localparam logic [7:0] ILLEGAL_OPCODE = 8'h3f;
    localparam logic [3:0] HARD_TRAP_LOW = 4'hd;
    localparam logic [3:0] HARD_TRAP_HIGH = 4'hf;
    localparam int NUM_WREGS = 16;
    localparam int PPS_WIDTH = 16;
    // Least pin low time in ns, and its cycle count at 20 MHz
    localparam int CLK_PERIOD_NS = 50;
    localparam int PIN_MIN_NS = 200;
    localparam int PIN_FILTER_CYC =
        (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] RESET_FLAGS = 16'h0000;
endpackage

/* hdl/pin_glitch_filter.sv */
// Glitch filter that passes a low level only after it stands long enough
`timescale 1ns/1ns
module pin_glitch_filter
    import reset_cause_pkg::*;
#(
    parameter int FILTER_CYC = PIN_FILTER_CYC
) (
    input wire logic mclk, // System clock
    input wire logic resetn, // Async reset, active low
    input wire logic pinIn_n, // Raw pin level, low asserts
    output logic pinLow // Filtered low indication
);
    typedef struct packed {
        logic [7:0] count;
        logic low;
    } filt_t;

    filt_t state_reg;
    filt_t state_next;

    // -----------------------------------------------------------------
    // Low time counter
    // -----------------------------------------------------------------
    // Count consecutive low cycles; any high restarts the count
    always_comb begin
        state_next = state_reg;
        if (pinIn_n) begin
            state_next.count = 8'h00;
            state_next.low = 1'b0;
        end else if (state_reg.count >= 8'(FILTER_CYC)) begin
            state_next.low = 1'b1;
        end else begin
            state_next.count = state_reg.count + 8'h01;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pinLow = state_reg.low;

    // Short pulse must never reach the output
    a_short_pulse: assert property (@(posedge mclk)
        disable iff (!resetn) $rose(pinLow)
        |-> $past(!pinIn_n) && $past(state_reg.count) >= 8'(FILTER_CYC))
        else $error("Filter passed a short pulse");
    // Any high sample on the pin drops the filtered output
    a_high_release: assert property (@(posedge mclk)
        disable iff (!resetn) pinIn_n |=> !pinLow)
        else $error("Filter held a released pin");
endmodule

/* tb/supervisor_model.sv */
// Model of an outside supervisor that pulls the reset pin low
`timescale 1ns/1ns
module supervisor_model (
    input wire logic mclk, // System clock
    input wire logic start, // Begin one low pulse
    input wire logic [7:0] lowCycles, // Pulse length in cycles
    output logic masterClearPin_n, // Driven reset pin, low asserts
    output logic busy // Pulse in progress
);
    logic [7:0] count_reg;

    // ---------------------------------------------------------------
    // Pulse generator
    // ---------------------------------------------------------------
    // Push-pull drive: the pin has no pull-up, so it never floats
    initial begin
        masterClearPin_n = 1'b1;
        busy = 1'b0;
        count_reg = 8'h00;
    end

    // Holds the pin low for the requested count, then releases it
    always @(posedge mclk) begin
        if (start && !busy) begin
            masterClearPin_n <= 1'b0;
            busy <= 1'b1;
            count_reg <= lowCycles;
        end else if (busy) begin
            if (count_reg == 8'h01) begin
                masterClearPin_n <= 1'b1;
                busy <= 1'b0;
            end
            count_reg <= count_reg - 8'h01;
        end
    end
endmodule

/* tb/reset_cause_bench.sv */
// Self-checking bench for the reset source collector
`timescale 1ns/1ns
module reset_cause_bench;
    import reset_cause_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic mclk = 1'b0, resetn = 1'b0, cpuAsleep = 1'b0, trapActive = 1'b0;
    logic watchdogTimeout = 1'b0, flowRestricted = 1'b0, read = 1'b0;
    logic write = 1'b0;
    // Pulsed event inputs, each one bit of pv, raised by pulse()
    localparam int EV_BROWN = 0, EV_SOFT = 1, EV_SLEEP = 2, EV_IDLE = 3;
    localparam int EV_WCLR = 4, EV_TRAP = 5, EV_FETCH = 6, EV_REGWR = 7;
    localparam int EV_PTR = 8, EV_FLOW = 9;
    logic [9:0] pv = 10'h000;
    wire logic brownOut = pv[EV_BROWN], softResetInstr = pv[EV_SOFT];
    wire logic sleepInstr = pv[EV_SLEEP], idleInstr = pv[EV_IDLE];
    wire logic watchdogClearInstr = pv[EV_WCLR], trapNew = pv[EV_TRAP];
    wire logic fetchValid = pv[EV_FETCH], regWrite = pv[EV_REGWR];
    wire logic ptrUse = pv[EV_PTR], flowChange = pv[EV_FLOW];
    logic [3:0] trapActiveLevel = 4'h0, trapNewLevel = 4'h0, ptrIdx = 4'h0;
    logic [3:0] regWriteIdx = 4'h0, address = 4'h0, byteenable = 4'hf;
    logic [15:0] ppsControl = 16'h0000;
    logic [23:0] fetchWord = 24'h000000;
    logic [31:0] writedata = 32'h00000000, readdata, rd;
    logic waitrequest, systemReset_n, warmReset, coldReset, wakeRequest;
    logic pinN, supStart = 1'b0, supBusy;
    logic [7:0] supCycles = 8'h00;
    int failCount = 0, checksDone = 0, rstCount = 0, r0;

    reset_cause dut_u (.mclk(mclk), .resetn(resetn), .brownOut(brownOut),
        .masterClearPin_n(pinN), .softResetInstr(softResetInstr),
        .watchdogTimeout(watchdogTimeout), .sleepInstr(sleepInstr),
        .idleInstr(idleInstr), .watchdogClearInstr(watchdogClearInstr),
        .cpuAsleep(cpuAsleep), .trapActive(trapActive),
        .trapActiveLevel(trapActiveLevel), .trapNew(trapNew),
        .trapNewLevel(trapNewLevel), .ppsControl(ppsControl),
        .fetchWord(fetchWord), .fetchValid(fetchValid), .regWrite(regWrite),
        .regWriteIdx(regWriteIdx), .ptrUse(ptrUse), .ptrIdx(ptrIdx),
        .flowChange(flowChange), .flowRestricted(flowRestricted),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .systemReset_n(systemReset_n),
        .warmReset(warmReset), .coldReset(coldReset),
        .wakeRequest(wakeRequest));
    supervisor_model sup_u (.mclk(mclk), .start(supStart),
        .lowCycles(supCycles), .masterClearPin_n(pinN), .busy(supBusy));

    // ---------------------------------------------------------------
    // Clock, reset counting and shared tasks
    // ---------------------------------------------------------------
    always #25 mclk = ~mclk;
    // Counts every assertion of the merged reset, glitches included
    always @(negedge systemReset_n) rstCount = rstCount + 1;

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checksDone++;
        if (seen !== exp) begin
            failCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One Avalon access; waits for waitrequest low, then releases
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        address <= a; writedata <= d; write <= wr; read <= !wr;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0; read <= 1'b0;
    endtask
    // One-cycle high pulse on the event input with the given index
    task automatic pulse(input int ev);
        @(posedge mclk);
        pv <= 10'h001 << ev;
        @(posedge mclk);
        pv <= 10'h000;
    endtask
    // Judges reset occurrence and flag value, then clears the flags
    task automatic expect_src(input string what, input logic rstExp,
                              input logic [15:0] fl);
        repeat (3) @(posedge mclk);
        chk({what, " reset"}, 32'(rstCount != r0), 32'(rstExp));
        bus(1'b0, ADDR_FLAGS, 32'h0);
        chk(what, rd, {16'h0, fl});
        bus(1'b1, ADDR_FLAGS, 32'h0);
        r0 = rstCount;
    endtask
    task automatic pin_pulse(input int n);
        @(posedge mclk); supStart <= 1'b1; supCycles <= 8'(n);
        @(posedge mclk); supStart <= 1'b0;
        repeat (n + 6) @(posedge mclk);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_regs;
        r0 = rstCount;
        bus(1'b0, ADDR_FLAGS, 32'h0); chk("power-on flags", rd, 32'h3);
        bus(1'b1, ADDR_FLAGS, 32'hffffffff);
        expect_src("all flags written", 1'b0, FLAG_MASK);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped read", rd, 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("status idle", rd, 32'h1);
        $display("Test registers done");
    endtask
    task automatic t_soft;
        pulse(EV_SOFT);
        #1 chk("soft reset low", systemReset_n, 1'b0);
        chk("soft warm", {warmReset, coldReset}, 2'b10);
        @(posedge mclk);
        #1 chk("soft reset released", systemReset_n, 1'b1);
        expect_src("soft flag", 1'b1, 16'h0040);
        $display("Test soft reset done");
    endtask
    task automatic t_pin;
        pin_pulse(PIN_FILTER_CYC);
        expect_src("short pin", 1'b0, 16'h0000);
        pin_pulse(2 * PIN_FILTER_CYC);
        expect_src("long pin", 1'b1, 16'h0080);
        $display("Test pin reset done");
    endtask
    task automatic t_wdog;
        @(posedge mclk); watchdogTimeout <= 1'b1;
        #1 chk("watchdog async", systemReset_n, 1'b0);
        @(posedge mclk); watchdogTimeout <= 1'b0;
        expect_src("watchdog flag", 1'b1, 16'h0010);
        bus(1'b1, ADDR_FLAGS, 32'h10);
        pulse(EV_WCLR);
        expect_src("watchdog clear", 1'b0, 16'h0000);
        @(posedge mclk); cpuAsleep <= 1'b1; watchdogTimeout <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk("wake on timeout", wakeRequest, 1'b1);
        @(posedge mclk);
        watchdogTimeout <= 1'b0;
        // Wake the core a cycle later so no awake time-out is ever seen
        @(posedge mclk);
        cpuAsleep <= 1'b0;
        pulse(EV_SLEEP);
        expect_src("asleep timeout", 1'b0, 16'h0008);
        pulse(EV_IDLE);
        expect_src("idle flag", 1'b0, 16'h0004);
        $display("Test watchdog done");
    endtask
    task automatic t_trap;
        @(posedge mclk); trapActive <= 1'b1;
        trapActiveLevel <= 4'he; trapNewLevel <= 4'hc;
        pulse(EV_TRAP);
        expect_src("soft trap", 1'b0, 16'h0000);
        @(posedge mclk); trapNewLevel <= 4'hd;
        pulse(EV_TRAP);
        @(posedge mclk); trapActive <= 1'b0;
        expect_src("trap conflict", 1'b1, 16'h8000);
        $display("Test trap conflict done");
    endtask
    task automatic t_illegal;
        @(posedge mclk); fetchWord <= 24'h3e1234; ptrIdx <= 4'hf;
        pulse(EV_FETCH);
        expect_src("legal opcode", 1'b0, 16'h0000);
        @(posedge mclk); fetchWord <= 24'h3f1234;
        pulse(EV_FETCH);
        expect_src("illegal opcode", 1'b1, 16'h4000);
        pulse(EV_PTR);
        expect_src("pointer 15", 1'b0, 16'h0000);
        @(posedge mclk); ptrIdx <= 4'h3; regWriteIdx <= 4'h3;
        pulse(EV_PTR);
        expect_src("uninit pointer", 1'b1, 16'h4000);
        pulse(EV_REGWR);
        pulse(EV_PTR);
        expect_src("written pointer", 1'b0, 16'h0000);
        @(posedge mclk); flowRestricted <= 1'b1;
        pulse(EV_FLOW);
        @(posedge mclk); flowRestricted <= 1'b0;
        expect_src("security", 1'b1, 16'h4000);
        $display("Test illegal conditions done");
    endtask
    task automatic t_config;
        bus(1'b1, ADDR_CONTROL, 32'h1);
        bus(1'b0, ADDR_CONTROL, 32'h0);
        chk("check enable", rd, 32'h1);
        @(posedge mclk); ppsControl <= 16'h00a5;
        repeat (3) @(posedge mclk);
        // Shadow stays frozen while the mismatch holds the reset
        bus(1'b0, ADDR_SHADOW, 32'h0);
        chk("frozen shadow", rd, 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("status in reset", rd, 32'h2);
        ppsControl <= 16'h0000;
        bus(1'b1, ADDR_CONTROL, 32'h0);
        expect_src("config mismatch", 1'b1, 16'h0200);
        $display("Test config mismatch done");
    endtask
    task automatic t_cold;
        bus(1'b1, ADDR_FLAGS, {16'h0, FLAG_MASK});
        pulse(EV_BROWN);
        #1 chk("brown-out kind", {systemReset_n, coldReset}, 2'b01);
        expect_src("brown-out", 1'b1, 16'h0083);
        bus(1'b1, ADDR_FLAGS, 32'h80);
        @(posedge mclk); resetn <= 1'b0;
        @(posedge mclk); resetn <= 1'b1;
        expect_src("power-on", 1'b1, 16'h0003);
        $display("Test cold resets done");
    endtask

    // ---------------------------------------------------------------
    // Run control
    // ---------------------------------------------------------------
    task automatic printVerdict;
        $display("Checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Sequence of scenarios after the power-on reset
    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        t_regs(); t_soft(); t_pin(); t_wdog();
        t_trap(); t_illegal(); t_config(); t_cold();
        printVerdict();
    end
    // Cuts a hang short; the tests need well under 2000 cycles
    initial begin
        #200000;
        failCount++;
        printVerdict();
    end
endmodule
